// ==== verilog/ehr_pkg.sv ====
// Shared constants and carrier types of the error history recorder.
// Assumes a 12-bit Avalon-MM byte address, one 32-bit word per register.
`default_nettype none

package ehr_pkg;

  // Register word indexes; byte address is four times the index
  localparam logic [9:0]  IDX_PTR       = 10'h3c9;
  localparam logic [9:0]  IDX_REC_FIRST = 10'h3ca;
  localparam logic [9:0]  IDX_REC_LAST  = 10'h3e7;
  localparam logic [9:0]  IDX_CTRL      = 10'h3f0;
  localparam logic [9:0]  IDX_FAULT     = 10'h3f1;

  // Record area geometry
  localparam int          REC_WORDS     = 30;
  localparam int          WORDS_PER_REC = 3;
  localparam logic [3:0]  REC_MAX       = 4'ha;
  localparam logic [3:0]  PTR_RESET     = 4'h0;
  localparam logic [15:0] WORD_RESET    = 16'h0000;

  // Control word field positions
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_OVW_BIT  = 1;
  localparam int          CTRL_CLR_BIT  = 2;
  localparam int          CTRL_SMP_LSB  = 4;

  // Record code word markers and the cycle-time fatal code
  localparam logic [7:0]  MARK_FATAL    = 8'h80;
  localparam logic [7:0]  MARK_NONFATAL = 8'h00;
  localparam logic [7:0]  CODE_CYCLE    = 8'h9f;
  localparam logic [15:0] BCD_SAT       = 16'h9999;

  // One error report from the scan logic
  typedef struct packed {
    logic [7:0]  code;
    logic        fatal;
    logic [15:0] prog_addr;
  } ehr_err_t;

  // History control bits
  typedef struct packed {
    logic clear;
    logic overwrite;
    logic enable;
  } ehr_ctrl_t;

  // Word index from a byte address
  function automatic logic [9:0] reg_index(logic [11:0] a);
    return a[11:2];
  endfunction

  // First memory word of the record that follows pointer p
  function automatic logic [4:0] rec_base(logic [3:0] p);
    return 5'({1'b0, p} * 5'h03);
  endfunction

endpackage

`default_nettype wire

// ==== verilog/ehr_bcd4.sv ====
// Binary to four-digit BCD converter for the fault source address.
// Assumes a combinational use; values above 9999 saturate.
`default_nettype none
`timescale 1ns/100ps

module ehr_bcd4 (
  input  wire logic [15:0] bin,
  output logic      [15:0] bcd
);

  // Shift-and-add-three; four BCD digits build up above the sixteen input bits
  always_comb begin
    logic [31:0] sh;
    sh = {16'h0000, bin};
    for (int i = 0; i < 16; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (sh[16 + 4*d +: 4] > 4'h4) begin
          sh[16 + 4*d +: 4] = 4'(sh[16 + 4*d +: 4] + 4'h3);
        end
      end
      sh = {sh[30:0], 1'b0};
    end
    if (bin > 16'h270f) begin
      bcd = ehr_pkg::BCD_SAT;
    end else begin
      bcd = sh[31:16];
    end
  end

endmodule

`default_nettype wire

// ==== verilog/ehr_scan_ctrl.sv ====
// Scan-cycle sampler for the history control bits.
// Assumes scan_tick is a one-cycle pulse from logic on clk.
`default_nettype none
`timescale 1ns/100ps

module ehr_scan_ctrl (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              scan_tick,
  input  wire ehr_pkg::ehr_ctrl_t ctrl_in,
  output ehr_pkg::ehr_ctrl_t     ctrl_q,
  output logic                   clear_pulse
);

  // Sample once per scan; a falling clear bit under enable clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q      <= '0;
      clear_pulse <= 1'b0;
    end else begin
      clear_pulse <= scan_tick & ctrl_q.clear & ~ctrl_in.clear & ctrl_in.enable;
      if (scan_tick) begin
        ctrl_q <= ctrl_in;
      end
    end
  end

  chk_ctrl_sample: assert property (@(posedge clk) disable iff (rst)
    !scan_tick |=> ctrl_q == $past(ctrl_q))
    else $error("control bits changed outside a scan tick");

endmodule

`default_nettype wire

// ==== verilog/ehr_recorder.sv ====
// Error history recorder: ten three-word records, pointer, fault address.
// Assumes an Avalon-MM master on clk and a scan logic on the same clock.
//
// Contract
// - Keep up to ten records of three 16-bit words, back to back.
// - Pointer holds last stored record number, 0 empty, 1 to 10.
// - Word one: error code low byte, 00 or 80 fatal marker high.
// - Word two minutes:seconds, word three day:hours from calendar words.
// - Capture system and user alarm codes only while enable is set.
// - Store after the pointed record, then increment the pointer.
// - Full with overwrite: shift records down, new one in record ten.
// - Full without overwrite: ignore further errors, keep records.
// - Clear on then off zeroes records and pointer.
// - Clear acts only with enable set; operator keeps enable on.
// - Time words valid only when a calendar clock is present.
// - Fatal alarm, including code 9F, gives BCD fault address, refreshed each scan.
// - Timestamp bytes are BCD copied from the calendar words.
// - Control bits are sampled once per scan cycle.
//
// Added by the designer: the Avalon-MM slave port.
`default_nettype none
`timescale 1ns/100ps

module ehr_recorder (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [11:0]       avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              scan_tick,
  input  wire logic              err_strobe,
  input  wire ehr_pkg::ehr_err_t err,
  input  wire logic [15:0]       calendar_sec_min_word,
  input  wire logic [15:0]       calendar_hour_day_word,
  input  wire logic              clock_present,
  output logic      [15:0]       fault_source_address_word,
  output logic                   history_full
);

  logic [15:0]        rec_mem [0:ehr_pkg::REC_WORDS-1];
  logic [3:0]         ptr;
  ehr_pkg::ehr_ctrl_t ctrl_reg;
  ehr_pkg::ehr_ctrl_t ctrl_q;
  logic               clear_pulse;
  logic               ack;
  logic [9:0]         idx;
  logic [9:0]         rec_off;
  logic               sw_wr;
  logic               sw_wr_rec;
  logic               sw_wr_ptr;
  logic [31:0]        next_readdata;
  logic               capture;
  logic               is_fatal;
  logic               do_append;
  logic               do_shift;
  logic [4:0]         base;
  logic [15:0]        new_w0;
  logic [15:0]        new_w1;
  logic [15:0]        new_w2;
  logic               fault_seen;
  logic [15:0]        fault_bin;
  logic [15:0]        fault_bcd;

  // Control bits sampled per scan, clear pulse on release
  ehr_scan_ctrl u_scan_ctrl (
    .clk         (clk),
    .rst         (rst),
    .scan_tick   (scan_tick),
    .ctrl_in     (ctrl_reg),
    .ctrl_q      (ctrl_q),
    .clear_pulse (clear_pulse)
  );

  // Fault address conversion to BCD
  ehr_bcd4 u_bcd4 (
    .bin (fault_bin),
    .bcd (fault_bcd)
  );

  // Bus decode; one wait cycle, answer at the second edge
  assign avs_waitrequest = ~ack;
  assign idx       = ehr_pkg::reg_index(avs_address);
  assign rec_off   = idx - ehr_pkg::IDX_REC_FIRST;
  assign sw_wr     = avs_write & ack;
  assign sw_wr_rec = sw_wr & (idx >= ehr_pkg::IDX_REC_FIRST) & (idx <= ehr_pkg::IDX_REC_LAST);
  assign sw_wr_ptr = sw_wr & (idx == ehr_pkg::IDX_PTR);

  // Request acknowledge toggles so every access takes two edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // Read mux; unmapped words read as zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (idx == ehr_pkg::IDX_PTR) begin
      next_readdata = {28'h000_0000, ptr};
    end else if (idx >= ehr_pkg::IDX_REC_FIRST && idx <= ehr_pkg::IDX_REC_LAST) begin
      next_readdata = {16'h0000, rec_mem[rec_off[4:0]]};
    end else if (idx == ehr_pkg::IDX_CTRL) begin
      next_readdata = {25'h000_0000, ctrl_q, 1'b0, ctrl_reg};
    end else if (idx == ehr_pkg::IDX_FAULT) begin
      next_readdata = {16'h0000, fault_source_address_word};
    end
  end

  // Read data held from the first request cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= next_readdata;
    end
  end

  // Control register written by software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= '0;
    end else if (sw_wr & (idx == ehr_pkg::IDX_CTRL)) begin
      ctrl_reg.enable    <= avs_writedata[ehr_pkg::CTRL_EN_BIT];
      ctrl_reg.overwrite <= avs_writedata[ehr_pkg::CTRL_OVW_BIT];
      ctrl_reg.clear     <= avs_writedata[ehr_pkg::CTRL_CLR_BIT];
    end
  end

  // Capture decision and new record words
  assign capture   = err_strobe & ctrl_q.enable;
  assign is_fatal  = err.fatal | (err.code == ehr_pkg::CODE_CYCLE);
  assign do_append = capture & (ptr < ehr_pkg::REC_MAX);
  assign do_shift  = capture & (ptr == ehr_pkg::REC_MAX) & ctrl_q.overwrite;
  assign base      = ehr_pkg::rec_base(ptr);
  assign new_w0    = {(is_fatal ? ehr_pkg::MARK_FATAL : ehr_pkg::MARK_NONFATAL), err.code};
  assign new_w1    = clock_present ? calendar_sec_min_word : ehr_pkg::WORD_RESET;
  assign new_w2    = clock_present ? calendar_hour_day_word : ehr_pkg::WORD_RESET;
  assign history_full = (ptr == ehr_pkg::REC_MAX);

  // Record memory; clear beats capture beats software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ehr_pkg::REC_WORDS; i++) begin
        rec_mem[i] <= ehr_pkg::WORD_RESET;
      end
    end else if (clear_pulse) begin
      for (int i = 0; i < ehr_pkg::REC_WORDS; i++) begin
        rec_mem[i] <= ehr_pkg::WORD_RESET;
      end
    end else if (do_append) begin
      rec_mem[base]         <= new_w0;
      rec_mem[5'(base + 1)] <= new_w1;
      rec_mem[5'(base + 2)] <= new_w2;
    end else if (do_shift) begin
      for (int i = 0; i < ehr_pkg::REC_WORDS - ehr_pkg::WORDS_PER_REC; i++) begin
        rec_mem[i] <= rec_mem[i + ehr_pkg::WORDS_PER_REC];
      end
      rec_mem[ehr_pkg::REC_WORDS-3] <= new_w0;
      rec_mem[ehr_pkg::REC_WORDS-2] <= new_w1;
      rec_mem[ehr_pkg::REC_WORDS-1] <= new_w2;
    end else if (sw_wr_rec) begin
      rec_mem[rec_off[4:0]] <= avs_writedata[15:0];
    end
  end

  // Record pointer; full pointer stays put on shift or ignore
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr <= ehr_pkg::PTR_RESET;
    end else if (clear_pulse) begin
      ptr <= ehr_pkg::PTR_RESET;
    end else if (do_append) begin
      ptr <= 4'(ptr + 4'h1);
    end else if (sw_wr_ptr && !capture) begin
      ptr <= (avs_writedata[15:0] > {12'h000, ehr_pkg::REC_MAX}) ? ehr_pkg::REC_MAX : avs_writedata[3:0];
    end
  end

  // Fatal program address latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_seen <= 1'b0;
      fault_bin  <= 16'h0000;
    end else if (err_strobe & is_fatal) begin
      fault_seen <= 1'b1;
      fault_bin  <= err.prog_addr;
    end
  end

  // Fault address word refreshed every scan once a fatal occurred
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_source_address_word <= 16'h0000;
    end else if (scan_tick & fault_seen) begin
      fault_source_address_word <= fault_bcd;
    end
  end

  // Checks on the recorder behaviour
  chk_ptr_range: assert property (@(posedge clk) disable iff (rst)
    ptr <= ehr_pkg::REC_MAX)
    else $error("record pointer above ten");

  chk_append_ptr: assert property (@(posedge clk) disable iff (rst)
    do_append && !clear_pulse |=> ptr == 4'($past(ptr) + 4'h1))
    else $error("pointer did not advance after a capture");

  chk_code_word: assert property (@(posedge clk) disable iff (rst)
    do_append && !clear_pulse |=> rec_mem[$past(base)] == $past(new_w0))
    else $error("code word wrong after a capture");

  chk_time_words: assert property (@(posedge clk) disable iff (rst)
    do_append && clock_present && !clear_pulse
      |=> rec_mem[5'($past(base) + 1)] == $past(calendar_sec_min_word)
          && rec_mem[5'($past(base) + 2)] == $past(calendar_hour_day_word))
    else $error("time words do not match the calendar");

  chk_no_clock: assert property (@(posedge clk) disable iff (rst)
    do_append && !clock_present && !clear_pulse |=> rec_mem[5'($past(base) + 1)] == 16'h0000)
    else $error("time word set without a calendar clock");

  chk_disabled_ignore: assert property (@(posedge clk) disable iff (rst)
    err_strobe && !ctrl_q.enable && !clear_pulse && !sw_wr_ptr |=> ptr == $past(ptr))
    else $error("error captured while history disabled");

  chk_shift_keep: assert property (@(posedge clk) disable iff (rst)
    do_shift && !clear_pulse
      |=> ptr == ehr_pkg::REC_MAX && rec_mem[0] == $past(rec_mem[3])
          && rec_mem[ehr_pkg::REC_WORDS-3] == $past(new_w0))
    else $error("overwrite shift wrong");

  chk_full_hold: assert property (@(posedge clk) disable iff (rst)
    capture && history_full && !ctrl_q.overwrite && !clear_pulse && !sw_wr
      |=> ptr == ehr_pkg::REC_MAX && rec_mem[ehr_pkg::REC_WORDS-3] == $past(rec_mem[ehr_pkg::REC_WORDS-3]))
    else $error("full history changed without overwrite");

  chk_clear_zero: assert property (@(posedge clk) disable iff (rst)
    clear_pulse |=> ptr == 4'h0 && rec_mem[0] == 16'h0000 && rec_mem[ehr_pkg::REC_WORDS-1] == 16'h0000)
    else $error("clear left data behind");

  chk_clear_enable: assert property (@(posedge clk) disable iff (rst)
    clear_pulse |-> ctrl_q.enable)
    else $error("clear acted while history disabled");

  chk_fault_bcd: assert property (@(posedge clk) disable iff (rst)
    scan_tick && fault_seen |=> fault_source_address_word == $past(fault_bcd))
    else $error("fault address word not refreshed");

  chk_bus_wait: assert property (@(posedge clk) disable iff (rst)
    (avs_read || avs_write) && !ack |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  // Bus answer, record word write and full-history pointer checks
  chk_read_stand: assert property (@(posedge clk) disable iff (rst)
    ack |=> avs_readdata == $past(avs_readdata))
    else $error("read data moved during the answer cycle");

  chk_single_wait: assert property (@(posedge clk) disable iff (rst)
    ack |=> !ack)
    else $error("bus answer lasted more than one cycle");

  chk_ptr_readback: assert property (@(posedge clk) disable iff (rst)
    ack && avs_read && idx == ehr_pkg::IDX_PTR |-> avs_readdata == {28'h000_0000, $past(ptr)})
    else $error("pointer read back wrong");

  chk_sw_rec_write: assert property (@(posedge clk) disable iff (rst)
    sw_wr_rec && !clear_pulse && !do_append && !do_shift
      |=> rec_mem[$past(rec_off[4:0])] == $past(avs_writedata[15:0]))
    else $error("record word write lost");

  chk_full_stay: assert property (@(posedge clk) disable iff (rst)
    capture && history_full && !clear_pulse |=> history_full)
    else $error("pointer left ten on a capture when full");

  // Fault address and cycle-time fatal marker checks
  chk_fault_latch: assert property (@(posedge clk) disable iff (rst)
    err_strobe && is_fatal |=> fault_seen && fault_bin == $past(err.prog_addr))
    else $error("fatal program address not latched");

  chk_bcd_digits: assert property (@(posedge clk) disable iff (rst)
    fault_bcd[15:12] <= 4'h9 && fault_bcd[11:8] <= 4'h9 && fault_bcd[7:4] <= 4'h9 && fault_bcd[3:0] <= 4'h9)
    else $error("fault address digit not decimal");

  chk_fault_idle: assert property (@(posedge clk) disable iff (rst)
    !fault_seen |-> fault_source_address_word == 16'h0000)
    else $error("fault address word set without a fatal alarm");

  chk_cycle_marker: assert property (@(posedge clk) disable iff (rst)
    do_shift && err.code == ehr_pkg::CODE_CYCLE && !clear_pulse
      |=> rec_mem[ehr_pkg::REC_WORDS-3][15:8] == ehr_pkg::MARK_FATAL)
    else $error("cycle-time code stored as non-fatal");

  cov_append:   cover property (@(posedge clk) disable iff (rst) do_append);
  cov_shift:    cover property (@(posedge clk) disable iff (rst) do_shift);
  cov_clear:    cover property (@(posedge clk) disable iff (rst) clear_pulse);
  cov_ignored:  cover property (@(posedge clk) disable iff (rst) capture && history_full && !ctrl_q.overwrite);
  cov_fault:    cover property (@(posedge clk) disable iff (rst) scan_tick && fault_seen);

endmodule

`default_nettype wire

// ==== bench/ehr_scan_model.sv ====
// Scan logic model: periodic scan ticks and queued error reports.
// Assumes the bench pushes reports into pend; one leaves per clock.
`timescale 1ns/100ps
`default_nettype none

module ehr_scan_model (
  input  wire logic         clk,
  input  wire logic         rst,
  output logic              scan_tick,
  output logic              err_strobe,
  output ehr_pkg::ehr_err_t err
);
  ehr_pkg::ehr_err_t pend[$];
  logic [3:0]        tick_cnt;

  // Scan cycle of sixteen clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt  <= 4'h0;
      scan_tick <= 1'b0;
    end else begin
      tick_cnt  <= tick_cnt + 4'h1;
      scan_tick <= (tick_cnt == 4'hf);
    end
  end

  // One strobe per clock; released report lines toggle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      err_strobe <= 1'b0;
      err        <= '0;
    end else if (pend.size() != 0) begin
      err_strobe <= 1'b1;
      err        <= pend.pop_front();
    end else begin
      err_strobe <= 1'b0;
      err        <= ~err;
    end
  end
endmodule

`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench of the error history recorder.
// Assumes ehr_pkg, ehr_recorder and ehr_scan_model are compiled.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic              clk, rst, avs_read, avs_write, avs_waitrequest;
  logic              err_strobe, scan_tick, clock_present, history_full;
  logic [11:0]       avs_address;
  logic [31:0]       avs_writedata, avs_readdata, exp_q[$];
  logic [15:0]       cal_sm, cal_hd, fault_word, exp_mem[30];
  ehr_pkg::ehr_err_t err;
  int                errors, checks_done, cyc, exp_ptr;
  logic              en, ovw, clr_q;
  logic [31:0]       xs;

  ehr_recorder DUT (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .scan_tick(scan_tick), .err_strobe(err_strobe), .err(err),
    .calendar_sec_min_word(cal_sm), .calendar_hour_day_word(cal_hd),
    .clock_present(clock_present), .fault_source_address_word(fault_word),
    .history_full(history_full));
  ehr_scan_model scan (.clk(clk), .rst(rst), .scan_tick(scan_tick),
    .err_strobe(err_strobe), .err(err));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  function automatic logic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction
  function automatic logic [7:0] bcd2(int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction
  function automatic logic [15:0] to_bcd(int v);
    int s;
    s = (v > 9999) ? 9999 : v;
    return {bcd2(s / 100), bcd2(s % 100)};
  endfunction

  task automatic fail(string m);
    errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic complete_run();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(logic wr, logic [9:0] i, logic [31:0] d);
    @(posedge clk);
    avs_address   <= {i, 2'b00};
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    if (!wr) exp_q.push_back(d);
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  // Control write, then two scan samples
  task automatic ctrl(logic c, logic o, logic e);
    bus(1'b1, ehr_pkg::IDX_CTRL, {29'h0, c, o, e});
    repeat (2) @(posedge clk iff scan_tick);
    settle();
    if (clr_q && !c && e) begin
      exp_mem = '{default: 16'h0000};
      exp_ptr = 0;
    end
    clr_q = c;
    en    = e;
    ovw   = o;
  endtask
  task automatic new_time();
    @(posedge clk);
    cal_sm <= {bcd2(rnd() % 60), bcd2(rnd() % 60)};
    cal_hd <= {bcd2(rnd() % 31 + 1), bcd2(rnd() % 24)};
    @(posedge clk);
  endtask
  // Queue a report and predict the record area
  task automatic raise(logic [7:0] c, logic f, logic [15:0] a);
    logic [15:0] w[3];
    w[0] = {(f || c == ehr_pkg::CODE_CYCLE) ? ehr_pkg::MARK_FATAL : ehr_pkg::MARK_NONFATAL, c};
    w[1] = clock_present ? cal_sm : 16'h0000;
    w[2] = clock_present ? cal_hd : 16'h0000;
    scan.pend.push_back(ehr_pkg::ehr_err_t'({c, f, a}));
    if (!en) return;
    if (exp_ptr == 10 && !ovw) return;
    if (exp_ptr == 10) begin
      for (int k = 0; k < 27; k++) exp_mem[k] = exp_mem[k + 3];
      exp_ptr = 9;
    end
    for (int k = 0; k < 3; k++) exp_mem[exp_ptr * 3 + k] = w[k];
    exp_ptr++;
  endtask
  task automatic check_all();
    bus(1'b0, ehr_pkg::IDX_PTR, 32'(exp_ptr));
    for (int k = 0; k < 30; k++) bus(1'b0, ehr_pkg::IDX_REC_FIRST + 10'(k), {16'h0000, exp_mem[k]});
    checks_done++;
    if (history_full !== (exp_ptr == 10)) fail("full flag");
  endtask

  // Read monitor takes the oldest expected value
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      checks_done++;
      if (exp_q.size() == 0 || avs_readdata !== exp_q[0]) fail("read data");
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end

  // Main sequence
  initial begin
    clk = 0; rst = 1; avs_read = 0; avs_write = 0; avs_address = '0; avs_writedata = '0;
    cal_sm = 16'h0000; cal_hd = 16'h0000; clock_present = 1; xs = 32'h0000_0020;
    exp_mem = '{default: 16'h0000}; exp_ptr = 0; en = 0; ovw = 0; clr_q = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, 10'h000, 32'h1234_5678);
    bus(1'b0, 10'h000, 32'h0000_0000);
    bus(1'b0, ehr_pkg::IDX_FAULT, 32'h0000_0000);
    check_all();
    new_time();
    raise(8'h11, 1'b0, 16'h0000);
    settle();
    check_all();
    ctrl(1'b0, 1'b0, 1'b1);
    bus(1'b0, ehr_pkg::IDX_CTRL, 32'h0000_0011);
    for (int n = 0; n < 5; n++) begin
      new_time();
      raise(8'(rnd() & 32'h7f), 1'(n), 16'(rnd() % 9000));
      raise(8'(rnd() & 32'h7f), 1'b1, 16'(rnd() % 9000));
      settle();
    end
    check_all();
    raise(8'h21, 1'b0, 16'h0000);
    settle();
    check_all();
    ctrl(1'b0, 1'b1, 1'b1);
    new_time();
    raise(8'h31, 1'b0, 16'h0000);
    raise(8'h32, 1'b1, 16'h0000);
    settle();
    check_all();
    clock_present <= 1'b0;
    new_time();
    raise(8'h33, 1'b0, 16'h0000);
    settle();
    check_all();
    clock_present <= 1'b1;
    @(posedge clk);
    raise(ehr_pkg::CODE_CYCLE, 1'b0, 16'd4321);
    repeat (2) @(posedge clk iff scan_tick);
    settle();
    bus(1'b0, ehr_pkg::IDX_FAULT, {16'h0000, to_bcd(4321)});
    raise(8'h42, 1'b1, 16'hffff);
    repeat (2) @(posedge clk iff scan_tick);
    settle();
    checks_done++;
    if (fault_word !== to_bcd(65535)) fail("fault word");
    ctrl(1'b1, 1'b1, 1'b0);
    ctrl(1'b0, 1'b1, 1'b0);
    check_all();
    ctrl(1'b1, 1'b0, 1'b1);
    ctrl(1'b0, 1'b0, 1'b1);
    check_all();
    new_time();
    raise(8'h55, 1'b0, 16'h0000);
    settle();
    check_all();
    bus(1'b1, ehr_pkg::IDX_PTR, 32'h0000_000f);
    bus(1'b0, ehr_pkg::IDX_PTR, 32'h0000_000a);
    bus(1'b1, ehr_pkg::IDX_REC_LAST, 32'h0000_abcd);
    bus(1'b0, ehr_pkg::IDX_REC_LAST, 32'h0000_abcd);
    settle();
    complete_run();
  end
endmodule

`default_nettype wire
